// >>> shared/ubt_consts.svh
`ifndef UBT_CONSTS_SVH
`define UBT_CONSTS_SVH

// Register byte offsets
`define UBT_OFF_CTRL   8'h00
`define UBT_OFF_DIV    8'h04
`define UBT_OFF_TXDATA 8'h08
`define UBT_OFF_RXDATA 8'h0c
`define UBT_OFF_STAT   8'h10

// Control register fields
`define UBT_CLKSEL_LSB 0
`define UBT_TPB_LSB    2
`define UBT_PAR_EN     5
`define UBT_PAR_ODD    6
`define UBT_STOP2      7
`define UBT_TX_EN      8
`define UBT_RX_EN      9

// Reset values
`define UBT_CTRL_RST   10'h000
`define UBT_DIV_RST    8'h00

// Down-count start values for 15, 16 and 17 ticks per bit
`define UBT_TOP15      5'h0e
`define UBT_TOP16      5'h0f
`define UBT_TOP17      5'h10

// Majority-vote window, down-count positions
`define UBT_SAMP_HI    5'h08
`define UBT_SAMP_LO    5'h06

// Data bits per frame, counted from frame bit 1
`define UBT_LAST_DATA  4'h8

`endif

// >>> shared/ubt_pkg.sv
package ubt_pkg;

    typedef enum logic [2:0] {
        TPB_16     = 3'b000,
        TPB_16_17  = 3'b001,
        TPB_15     = 3'b010,
        TPB_15_16  = 3'b011,
        TPB_17     = 3'b100
    } ubt_tpb_t;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_START = 3'b001,
        PH_DATA  = 3'b010,
        PH_PAR   = 3'b011,
        PH_STOP1 = 3'b100,
        PH_STOP2 = 3'b101
    } ubt_phase_t;

    typedef struct packed {
        logic [2:0]  src_div;
        logic [7:0]  div_cnt;
        logic [1:0]  divider_clock_select;
        ubt_tpb_t    ticks_per_bit_code;
        logic        parity_enable_bit;
        logic        par_odd;
        logic        stop_length_select;
        logic        tx_en;
        logic        rx_en;
        logic [7:0]  baud_divider_value;
        ubt_phase_t  tx_ph;
        logic [4:0]  tx_cnt;
        logic [3:0]  tx_idx;
        logic [7:0]  tx_sh;
        logic        tx_par;
        logic        serial_out_line;
        ubt_phase_t  rx_ph;
        logic [4:0]  rx_cnt;
        logic [3:0]  rx_idx;
        logic [7:0]  rx_sh;
        logic [2:0]  rx_votes;
        logic        rx_prev;
        logic        rx_perr_pend;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        rx_perr;
        logic        rx_ferr;
        logic [31:0] prdata;
    } ubt_state_t;

endpackage : ubt_pkg

// >>> design/ubt_top.sv
// How it works
// - Tick every divider-plus-one source pulses
// - Each bit lasts 15 to 17 ticks
// - Codes 000/010/100 give 16/15/17 ticks
// - Codes 001/011 alternate, start bit shorter
// - Receive starts on line falling edge
// - Down-count from 16/15/14 to zero
// - Vote three samples at 8,7,6
// - Vote positions fixed for any length
// - High start vote abandons the frame
// - Parity even/odd/off, one or two stops
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ubt_consts.svh"

module ubt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("ubt_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;

    // Extra pointer bit tells full from empty
    assign in_ready  = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_valid && out_ready) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (in_valid && in_ready) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule : ubt_fifo

module ubt_top #(
    parameter int TX_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        serial_in_line,
    output logic             serial_out_line
);
    ubt_pkg::ubt_state_t s_reg;
    ubt_pkg::ubt_state_t s_next;

    logic       src_pulse;
    logic       tick;
    logic       fall;
    logic       samp_en;
    logic       maj;
    logic       acc;
    logic       mapped;
    logic       tx_push;
    logic       tx_in_ready;
    logic       tx_out_valid;
    logic       tx_pop;
    logic [7:0] tx_data;

    function automatic logic [4:0] tick_top(ubt_pkg::ubt_tpb_t code, logic odd);
        unique case (code)
            ubt_pkg::TPB_16:    tick_top = `UBT_TOP16;
            ubt_pkg::TPB_16_17: tick_top = odd ? `UBT_TOP17 : `UBT_TOP16;
            ubt_pkg::TPB_15:    tick_top = `UBT_TOP15;
            ubt_pkg::TPB_15_16: tick_top = odd ? `UBT_TOP16 : `UBT_TOP15;
            ubt_pkg::TPB_17:    tick_top = `UBT_TOP17;
            default:            tick_top = `UBT_TOP16;
        endcase
    endfunction : tick_top

    function automatic ubt_pkg::ubt_phase_t next_ph(ubt_pkg::ubt_phase_t ph,
            logic [3:0] idx, logic par, logic two_stop);
        unique case (ph)
            ubt_pkg::PH_START: next_ph = ubt_pkg::PH_DATA;
            ubt_pkg::PH_DATA:  next_ph = idx != `UBT_LAST_DATA ? ubt_pkg::PH_DATA
                                       : par ? ubt_pkg::PH_PAR : ubt_pkg::PH_STOP1;
            ubt_pkg::PH_PAR:   next_ph = ubt_pkg::PH_STOP1;
            ubt_pkg::PH_STOP1: next_ph = two_stop ? ubt_pkg::PH_STOP2 : ubt_pkg::PH_IDLE;
            default:           next_ph = ubt_pkg::PH_IDLE;
        endcase
    endfunction : next_ph

    assign acc     = psel && penable;
    assign mapped  = paddr == `UBT_OFF_CTRL || paddr == `UBT_OFF_DIV
                  || paddr == `UBT_OFF_TXDATA || paddr == `UBT_OFF_RXDATA
                  || paddr == `UBT_OFF_STAT;
    assign tx_push = acc && pwrite && paddr == `UBT_OFF_TXDATA;
    // A full FIFO stalls the bus write rather than dropping the byte
    assign pready  = !(tx_push && !tx_in_ready);
    assign pslverr = acc && !mapped;
    assign prdata  = s_reg.prdata;
    assign serial_out_line = s_reg.serial_out_line;
    assign tx_pop  = s_reg.tx_en && s_reg.tx_ph == ubt_pkg::PH_IDLE && tick;
    assign fall    = s_reg.rx_prev && !serial_in_line;
    assign samp_en = tick && s_reg.rx_ph != ubt_pkg::PH_IDLE
                  && s_reg.rx_cnt <= `UBT_SAMP_HI && s_reg.rx_cnt >= `UBT_SAMP_LO;
    assign maj     = (s_reg.rx_votes[0] & s_reg.rx_votes[1])
                  | (s_reg.rx_votes[1] & s_reg.rx_votes[2])
                  | (s_reg.rx_votes[0] & s_reg.rx_votes[2]);

    ubt_fifo #(
        .WIDTH (8),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data)
    );

    // Tick from registered state only, keeps tx_pop out of a loop
    always_comb begin
        src_pulse = 1'b0;
        unique case (s_reg.divider_clock_select)
            2'h0: src_pulse = 1'b1;
            2'h1: src_pulse = s_reg.src_div[0];
            2'h2: src_pulse = &s_reg.src_div[1:0];
            2'h3: src_pulse = &s_reg.src_div;
        endcase
        tick = src_pulse && s_reg.div_cnt >= s_reg.baud_divider_value;
    end

    always_comb begin
        s_next = s_reg;

        s_next.src_div = s_reg.src_div + 3'h1;
        if (src_pulse) begin
            if (tick) begin
                s_next.div_cnt = 8'h00;
            end else begin
                s_next.div_cnt = s_reg.div_cnt + 8'h01;
            end
        end

        // Register access
        if (acc && pwrite && paddr == `UBT_OFF_CTRL) begin
            s_next.divider_clock_select = pwdata[`UBT_CLKSEL_LSB +: 2];
            s_next.ticks_per_bit_code   = ubt_pkg::ubt_tpb_t'(pwdata[`UBT_TPB_LSB +: 3]);
            s_next.parity_enable_bit    = pwdata[`UBT_PAR_EN];
            s_next.par_odd              = pwdata[`UBT_PAR_ODD];
            s_next.stop_length_select   = pwdata[`UBT_STOP2];
            s_next.tx_en                = pwdata[`UBT_TX_EN];
            s_next.rx_en                = pwdata[`UBT_RX_EN];
        end
        if (acc && pwrite && paddr == `UBT_OFF_DIV) begin
            s_next.baud_divider_value = pwdata[7:0];
        end
        if (psel && !penable && !pwrite) begin
            s_next.prdata = 32'h0000_0000;
            unique case (paddr)
                `UBT_OFF_CTRL: s_next.prdata[9:0] = {s_reg.rx_en, s_reg.tx_en,
                    s_reg.stop_length_select, s_reg.par_odd, s_reg.parity_enable_bit,
                    s_reg.ticks_per_bit_code, s_reg.divider_clock_select};
                `UBT_OFF_DIV:    s_next.prdata[7:0] = s_reg.baud_divider_value;
                `UBT_OFF_RXDATA: s_next.prdata[7:0] = s_reg.rx_data;
                `UBT_OFF_STAT:   s_next.prdata[5:0] = {s_reg.rx_ferr, s_reg.rx_perr,
                    s_reg.rx_valid, s_reg.tx_ph != ubt_pkg::PH_IDLE,
                    !tx_in_ready, !tx_out_valid};
                default: ;
            endcase
        end
        // Reading the data clears the flags; a new frame below wins
        if (acc && !pwrite && paddr == `UBT_OFF_RXDATA) begin
            s_next.rx_valid = 1'b0;
            s_next.rx_perr  = 1'b0;
            s_next.rx_ferr  = 1'b0;
        end

        // Transmitter, starts on a tick so the start bit is whole
        if (tx_pop && tx_out_valid) begin
            s_next.tx_ph  = ubt_pkg::PH_START;
            s_next.tx_idx = 4'h0;
            s_next.tx_cnt = tick_top(s_reg.ticks_per_bit_code, 1'b0);
            s_next.tx_sh  = tx_data;
            s_next.tx_par = ^tx_data ^ s_reg.par_odd;
            s_next.serial_out_line = 1'b0;
        end else if (tick && s_reg.tx_ph != ubt_pkg::PH_IDLE) begin
            if (s_reg.tx_cnt != 5'h00) begin
                s_next.tx_cnt = s_reg.tx_cnt - 5'h01;
            end else begin
                s_next.tx_ph  = next_ph(s_reg.tx_ph, s_reg.tx_idx,
                    s_reg.parity_enable_bit, s_reg.stop_length_select);
                s_next.tx_idx = s_reg.tx_idx + 4'h1;
                s_next.tx_cnt = tick_top(s_reg.ticks_per_bit_code, !s_reg.tx_idx[0]);
                if (s_reg.tx_ph == ubt_pkg::PH_DATA) begin
                    s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
                end
                unique case (s_next.tx_ph)
                    ubt_pkg::PH_DATA: s_next.serial_out_line = s_next.tx_sh[0];
                    ubt_pkg::PH_PAR:  s_next.serial_out_line = s_reg.tx_par;
                    default:          s_next.serial_out_line = 1'b1;
                endcase
            end
        end

        // Receiver
        s_next.rx_prev = serial_in_line;
        if (s_reg.rx_ph == ubt_pkg::PH_IDLE) begin
            if (s_reg.rx_en && fall) begin
                s_next.rx_ph    = ubt_pkg::PH_START;
                s_next.rx_idx   = 4'h0;
                s_next.rx_cnt   = tick_top(s_reg.ticks_per_bit_code, 1'b0);
                s_next.rx_votes = 3'h0;
            end
        end else if (tick) begin
            if (samp_en) begin
                s_next.rx_votes = {s_reg.rx_votes[1:0], serial_in_line};
            end
            if (s_reg.rx_cnt != 5'h00) begin
                s_next.rx_cnt = s_reg.rx_cnt - 5'h01;
            end else begin
                s_next.rx_ph  = next_ph(s_reg.rx_ph, s_reg.rx_idx,
                    s_reg.parity_enable_bit, 1'b0);
                s_next.rx_idx = s_reg.rx_idx + 4'h1;
                s_next.rx_cnt = tick_top(s_reg.ticks_per_bit_code, !s_reg.rx_idx[0]);
                unique case (s_reg.rx_ph)
                    ubt_pkg::PH_START: if (maj) s_next.rx_ph = ubt_pkg::PH_IDLE;
                    ubt_pkg::PH_DATA:  s_next.rx_sh = {maj, s_reg.rx_sh[7:1]};
                    ubt_pkg::PH_PAR:   s_next.rx_perr_pend = maj ^ (^s_reg.rx_sh) ^ s_reg.par_odd;
                    default: begin
                        // Second stop bit needs no check; line is idle high
                        s_next.rx_data  = s_reg.rx_sh;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_ferr  = !maj;
                        s_next.rx_perr  = s_reg.parity_enable_bit && s_reg.rx_perr_pend;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{
                ticks_per_bit_code: ubt_pkg::TPB_16,
                tx_ph:              ubt_pkg::PH_IDLE,
                rx_ph:              ubt_pkg::PH_IDLE,
                baud_divider_value: `UBT_DIV_RST,
                serial_out_line:    1'b1,
                rx_prev:            1'b1,
                default:            '0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    tick_period_a: assert property (
        tick && s_reg.divider_clock_select == 2'h0 && s_reg.baud_divider_value == 8'h03
        && !(acc && pwrite) |=> (!tick [*3] ##1 tick) or (##[0:3] (acc && pwrite)))
        else $error("tick spacing wrong for divider 3");
    rx_start_a: assert property (
        s_reg.rx_ph == ubt_pkg::PH_IDLE && s_reg.rx_en && fall
        |=> s_reg.rx_ph == ubt_pkg::PH_START)
        else $error("falling edge did not start reception");
    rx_first_count_a: assert property (
        s_reg.rx_ph == ubt_pkg::PH_IDLE && s_reg.rx_en && fall && !(acc && pwrite)
        |=> s_reg.rx_cnt == tick_top(s_reg.ticks_per_bit_code, 1'b0))
        else $error("start bit count loaded wrong");
    vote_window_a: assert property (
        tick && s_reg.rx_ph != ubt_pkg::PH_IDLE
        && !(s_reg.rx_cnt inside {5'h08, 5'h07, 5'h06}) |=> $stable(s_reg.rx_votes))
        else $error("sample taken outside positions 8 to 6");
    vote_take_a: assert property (
        tick && s_reg.rx_ph != ubt_pkg::PH_IDLE && s_reg.rx_cnt inside {5'h08, 5'h07, 5'h06}
        |=> s_reg.rx_votes[0] == $past(serial_in_line))
        else $error("sample not taken at positions 8 to 6");
    false_start_a: assert property (
        tick && s_reg.rx_ph == ubt_pkg::PH_START && s_reg.rx_cnt == 5'h00 && maj
        |=> s_reg.rx_ph == ubt_pkg::PH_IDLE)
        else $error("false start not abandoned");
    fixed_len_a: assert property (
        tick && s_reg.tx_ph != ubt_pkg::PH_IDLE && s_reg.tx_cnt == 5'h00
        && s_reg.ticks_per_bit_code == ubt_pkg::TPB_15 |=> s_reg.tx_cnt == 5'h0e)
        else $error("fixed 15-tick bit loaded wrong");
    alt_len_a: assert property (
        tick && s_reg.tx_ph != ubt_pkg::PH_IDLE && s_reg.tx_cnt == 5'h00
        && s_reg.ticks_per_bit_code == ubt_pkg::TPB_16_17
        |=> s_reg.tx_cnt == (s_reg.tx_idx[0] ? 5'h10 : 5'h0f))
        else $error("alternating bit length wrong");
    tx_hold_a: assert property (
        s_reg.tx_ph != ubt_pkg::PH_IDLE && !(tick && s_reg.tx_cnt == 5'h00)
        |=> $stable(serial_out_line))
        else $error("output bit changed mid-bit");
    tx_start_low_a: assert property (
        s_reg.tx_ph == ubt_pkg::PH_START |-> !serial_out_line)
        else $error("start bit not low");
    tx_parity_a: assert property (
        s_reg.tx_ph == ubt_pkg::PH_PAR |-> serial_out_line == s_reg.tx_par)
        else $error("parity bit wrong");

    rx_frame_c: cover property (s_reg.rx_ph == ubt_pkg::PH_STOP1 ##1 s_reg.rx_valid);
    false_start_c: cover property (tick && s_reg.rx_ph == ubt_pkg::PH_START
        && s_reg.rx_cnt == 5'h00 && maj);
    tx_frame_c: cover property (s_reg.tx_ph == ubt_pkg::PH_STOP2
        ##1 s_reg.tx_ph == ubt_pkg::PH_IDLE);
    fifo_full_c: cover property (tx_push && !tx_in_ready);
endmodule : ubt_top

`default_nettype wire

// >>> tb/ubt_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module ubt_far_end #(
    parameter int BIT = 16
) (
    // Clock
    input  wire logic pclk,
    // Serial lines
    output logic      to_dut,
    input  wire logic from_dut
);
    int         gaps[$];
    logic [7:0] got[$];
    int         run = 0;
    logic       last = 1'b1;

    initial to_dut = 1'b1;

    // Run lengths of the device output, one entry per level change
    always @(posedge pclk) begin
        if (from_dut !== last) begin
            gaps.push_back(run);
            run = 1;
            last = from_dut;
        end else begin
            run = run + 1;
        end
    end

    // Mid-bit decoder, only meaningful at BIT cycles per bit
    always begin : dec
        logic [7:0] d;
        @(negedge from_dut);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge pclk);
            d[i] = from_dut;
        end
        repeat (BIT) @(posedge pclk);
        got.push_back(d);
    end

    // Even-numbered bits take la cycles, odd ones lb
    task automatic send(input logic [7:0] d, input int la, input int lb, input logic pen,
                        input logic odd, input logic s2, input logic flip);
        logic [11:0] bits;
        int          n;
        bits = {2'b11, pen ? (^d ^ odd ^ flip) : 1'b1, d, 1'b0};
        n = 10 + int'(pen) + int'(s2);
        @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            to_dut <= bits[i];
            repeat ((i % 2) ? lb : la) @(posedge pclk);
        end
    endtask : send

    // Short low pulse that must not be taken as a start bit
    task automatic glitch(input int len);
        @(posedge pclk);
        to_dut <= 1'b0;
        repeat (len) @(posedge pclk);
        to_dut <= 1'b1;
    endtask : glitch
endmodule : ubt_far_end

`default_nettype wire

// >>> tb/ubt_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubt_consts.svh"

module ubt_top_bench;
    typedef struct {
        logic [2:0] code;
        logic [7:0] div;
        logic [1:0] sel;
        logic       pen, odd, s2;
        int         s, l;
        logic [7:0] rxd;
    } ubt_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        serial_in_line, serial_out_line;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          waits = 0;
    ubt_row_t    rows[10];

    ubt_top #(.TX_DEPTH(16)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line));

    ubt_far_end #(.BIT(16)) p (.pclk(pclk), .to_dut(serial_in_line), .from_dut(serial_out_line));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // Budget covers all tables plus a wide margin
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        waits = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            waits++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    function automatic logic [31:0] ctrl(ubt_row_t r, logic tx, logic rx);
        return 32'(r.sel) | (32'(r.code) << `UBT_TPB_LSB) | (32'(r.pen) << `UBT_PAR_EN)
             | (32'(r.odd) << `UBT_PAR_ODD) | (32'(r.s2) << `UBT_STOP2)
             | (32'(tx) << `UBT_TX_EN) | (32'(rx) << `UBT_RX_EN);
    endfunction : ctrl

    // Polls the busy flag; stale reads only cost one more loop
    task automatic idle_tx;
        do begin
            apb(1'b0, `UBT_OFF_STAT, 32'h0);
        end while (rd[2] !== 1'b0);
    endtask : idle_tx

    initial begin : main
        int t;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows[0] = '{3'b000, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0, 16, 16, 8'ha5};
        rows[1] = '{3'b001, 8'h00, 2'h0, 1'b1, 1'b0, 1'b0, 16, 17, 8'h3c};
        rows[2] = '{3'b010, 8'h00, 2'h0, 1'b1, 1'b1, 1'b0, 15, 15, 8'h81};
        rows[3] = '{3'b011, 8'h00, 2'h0, 1'b0, 1'b0, 1'b1, 15, 16, 8'h7e};
        rows[4] = '{3'b100, 8'h00, 2'h0, 1'b1, 1'b0, 1'b1, 17, 17, 8'h00};
        rows[5] = '{3'b000, 8'h03, 2'h0, 1'b0, 1'b0, 1'b0, 16, 16, 8'hff};
        rows[6] = '{3'b000, 8'h01, 2'h1, 1'b1, 1'b1, 1'b1, 16, 16, 8'h69};
        rows[7] = '{3'b111, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0, 16, 16, 8'hc3};
        rows[8] = '{3'b100, 8'h00, 2'h3, 1'b0, 1'b0, 1'b0, 17, 17, 8'h12};
        rows[9] = '{3'b010, 8'h01, 2'h2, 1'b1, 1'b0, 1'b0, 15, 15, 8'he7};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'(serial_out_line), 32'h1);
        rdc(`UBT_OFF_CTRL, 32'h0);
        rdc(`UBT_OFF_DIV, 32'h0);
        rdc(`UBT_OFF_STAT, 32'h1);
        apb(1'b1, 8'h14, 32'hffff_ffff);
        chk(32'(er), 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            t = (32'(rows[i].div) + 1) << rows[i].sel;
            wr(`UBT_OFF_DIV, 32'(rows[i].div));
            wr(`UBT_OFF_CTRL, ctrl(rows[i], 1'b1, 1'b1));
            p.gaps.delete();
            fork
                wr(`UBT_OFF_TXDATA, 32'h55);
                p.send(rows[i].rxd, rows[i].s * t, rows[i].l * t, rows[i].pen,
                       rows[i].odd, rows[i].s2, 1'b0);
            join
            idle_tx();
            chk(p.gaps[1], rows[i].s * t);
            chk(p.gaps[2], rows[i].l * t);
            rdc(`UBT_OFF_STAT, 32'h9);
            rdc(`UBT_OFF_RXDATA, 32'(rows[i].rxd));
        end
        // False start, then a real frame
        wr(`UBT_OFF_DIV, 32'h0);
        wr(`UBT_OFF_CTRL, ctrl(rows[0], 1'b1, 1'b1));
        p.glitch(4);
        repeat (200) @(posedge pclk);
        rdc(`UBT_OFF_STAT, 32'h1);
        p.send(8'h96, 16, 16, 1'b0, 1'b0, 1'b0, 1'b0);
        rdc(`UBT_OFF_RXDATA, 32'h96);
        // Wrong parity is flagged, clear by data read
        wr(`UBT_OFF_CTRL, ctrl(rows[1], 1'b1, 1'b1));
        p.send(8'h5a, 16, 17, 1'b1, 1'b0, 1'b0, 1'b1);
        rdc(`UBT_OFF_STAT, 32'h19);
        rdc(`UBT_OFF_RXDATA, 32'h5a);
        rdc(`UBT_OFF_STAT, 32'h1);
        // Low parity bit where the stop is due is a framing error
        wr(`UBT_OFF_CTRL, ctrl(rows[0], 1'b1, 1'b1));
        p.send(8'h33, 16, 16, 1'b1, 1'b0, 1'b0, 1'b0);
        rdc(`UBT_OFF_STAT, 32'h29);
        rdc(`UBT_OFF_RXDATA, 32'h33);
        // Fill with transmit held off, then drain with the last write stalled
        wr(`UBT_OFF_CTRL, ctrl(rows[0], 1'b0, 1'b0));
        p.got.delete();
        for (int i = 0; i < 16; i++) wr(`UBT_OFF_TXDATA, 32'(i * 7 + 1));
        rdc(`UBT_OFF_STAT, 32'h2);
        wr(`UBT_OFF_CTRL, ctrl(rows[0], 1'b1, 1'b0));
        for (int i = 16; i < 18; i++) wr(`UBT_OFF_TXDATA, 32'(i * 7 + 1));
        chk(32'(waits > 2), 32'h1);
        while (p.got.size() < 18) @(posedge pclk);
        for (int i = 0; i < 18; i++) chk(32'(p.got[i]), 32'(i * 7 + 1));
        idle_tx();
        rdc(`UBT_OFF_STAT, 32'h1);
        // Reset in mid-frame
        wr(`UBT_OFF_TXDATA, 32'h0);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(serial_out_line), 32'h1);
        presetn <= 1'b1;
        rdc(`UBT_OFF_CTRL, 32'h0);
        rdc(`UBT_OFF_STAT, 32'h1);
        complete_run();
    end
endmodule : ubt_top_bench

`default_nettype wire
